// >>> common/bssfs_pkg.sv
// package: constants and carrier types for the boost soft-start and fault sequencer
`default_nettype none
package bssfs_pkg;
	localparam int unsigned CLK_HZ = 200000000;
	localparam int unsigned NUM_STRINGS = 4;
	localparam int unsigned SLEEP_TIME_MS = 120;
	localparam int unsigned STEP_TIME_MS = 2;
	localparam int unsigned SLEEP_CYCLES = (CLK_HZ / 1000) * SLEEP_TIME_MS;
	localparam int unsigned STEP_CYCLES = (CLK_HZ / 1000) * STEP_TIME_MS;
	localparam int unsigned LIMIT_FIRST = 1;
	localparam int unsigned LIMIT_FULL = 9;
	localparam int unsigned FAULT_PWM_CYCLES = 6;
	localparam int unsigned MAX_DOWN_BEFORE_ALL = 3;
	localparam logic [3:0] LIMIT_FIRST_L = 4'h1;
	localparam logic [3:0] LIMIT_FULL_L = 4'h9;
	localparam logic [3:0] LIMIT_OFF_L = 4'h0;
	localparam logic [2:0] FAULT_PWM_L = 3'h6;
	localparam logic [2:0] MAX_DOWN_L = 3'h3;

	typedef enum logic [2:0] {
		BSSFS_OFF = 3'h0,
		BSSFS_SOFT = 3'h1,
		BSSFS_RUN = 3'h2,
		BSSFS_SLEEP = 3'h3,
		BSSFS_LATCH = 3'h4
	} bssfs_state_e;

	// per-string analog comparator results
	typedef struct packed {
		logic short_check;
		logic at_target;
		logic grounded;
	} bssfs_sense_s;

	// per-string status reported back
	typedef struct packed {
		logic enabled;
		logic good;
		logic faulted;
	} bssfs_status_s;
endpackage : bssfs_pkg
`default_nettype wire

// >>> hw/bssfs_timer.sv
// module: interval counter that pulses when a programmed count elapses
`timescale 1ns/100ps
`default_nettype none
module bssfs_timer #(
	parameter int unsigned COUNT = 400000
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_clear,
	input wire logic i_run,
	output logic o_done
);
	localparam int unsigned W = $clog2(COUNT + 1);
	localparam logic [W-1:0] LAST = W'(COUNT - 1);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic next_done;

	always_comb
	begin
		next_cnt = cnt;
		next_done = 1'b0;
		if (i_clear)
			next_cnt = '0;
		else if (i_run)
		begin
			if (cnt == LAST)
			begin
				next_cnt = '0;
				next_done = 1'b1;
			end
			else
				next_cnt = cnt + W'(1);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt <= '0;
			o_done <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			o_done <= next_done;
		end
	end
endmodule : bssfs_timer
`default_nettype wire

// >>> hw/bssfs_string.sv
// module: fault supervision of one led string
`timescale 1ns/100ps
`default_nettype none
module bssfs_string (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_active,
	input wire logic i_start,
	input wire logic i_stable,
	input wire logic i_pwm_start,
	input wire logic i_overvoltage,
	input wire logic i_kill_all,
	input wire bssfs_pkg::bssfs_sense_s i_sense,
	output bssfs_pkg::bssfs_status_s o_status,
	output logic o_fault_now
);
	logic enabled;
	logic good;
	logic faulted;
	logic [2:0] cnt;
	logic next_enabled;
	logic next_good;
	logic next_faulted;
	logic [2:0] next_cnt;
	logic suspect;
	logic next_fault_now;

	always_comb
	begin
		next_enabled = enabled;
		next_good = good;
		next_faulted = faulted;
		next_cnt = cnt;
		next_fault_now = 1'b0;
		// short above lowest pin, dropped current after good, or overvoltage while not good
		suspect = i_sense.short_check | (good & ~i_sense.at_target) | (i_overvoltage & ~good);
		if (!i_active)
		begin
			next_enabled = 1'b0;
			next_good = 1'b0;
			next_faulted = 1'b0;
			next_cnt = '0;
		end
		else if (i_start)
		begin
			next_enabled = ~i_sense.grounded;
			next_good = 1'b0;
			next_faulted = 1'b0;
			next_cnt = '0;
		end
		else if (i_kill_all)
			next_enabled = 1'b0;
		else if (enabled)
		begin
			if (i_sense.at_target)
				next_good = 1'b1;
			// transients reset the timeout so nothing faults out while unstable
			if (!suspect || !i_stable)
				next_cnt = '0;
			else if (i_pwm_start)
			begin
				if (cnt == bssfs_pkg::FAULT_PWM_L - 3'h1)
				begin
					next_enabled = 1'b0;
					next_faulted = 1'b1;
					next_fault_now = 1'b1;
					next_cnt = '0;
				end
				else
					next_cnt = cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			enabled <= 1'b0;
			good <= 1'b0;
			faulted <= 1'b0;
			cnt <= '0;
			o_fault_now <= 1'b0;
		end
		else
		begin
			enabled <= next_enabled;
			good <= next_good;
			faulted <= next_faulted;
			cnt <= next_cnt;
			o_fault_now <= next_fault_now;
		end
	end

	assign o_status = '{enabled: enabled, good: good, faulted: faulted};
endmodule : bssfs_string
`default_nettype wire

// >>> hw/bssfs_top.sv
// module: top of the boost soft-start and fault sequencer
`timescale 1ns/100ps
`default_nettype none
module bssfs_top #(
	parameter int unsigned NUM_STRINGS = bssfs_pkg::NUM_STRINGS,
	parameter int unsigned SLEEP_CYCLES = bssfs_pkg::SLEEP_CYCLES,
	parameter int unsigned STEP_CYCLES = bssfs_pkg::STEP_CYCLES
) (
	input wire logic I_MCLK,
	input wire logic I_RESETN,
	input wire logic I_ENABLE,
	input wire logic I_INPUT_UNDERVOLTAGE_LOCKOUT,
	input wire logic I_INPUT_SUPPLY_OVERVOLTAGE,
	input wire logic I_OVER_TEMPERATURE,
	input wire logic I_OUTPUT_OVERVOLTAGE_LIMIT,
	input wire logic I_STABLE,
	input wire logic I_PWM_CYCLE_START,
	input wire logic I_DIRECT_PWM_MODE,
	input wire logic I_LEVEL_PICK_INPUT,
	input wire logic [NUM_STRINGS-1:0] I_LED_STRING_ON,
	input wire bssfs_pkg::bssfs_sense_s [NUM_STRINGS-1:0] I_SENSE,
	output logic O_BOOST_SWITCH_EN,
	output logic O_LIGHT_LOAD_PULSE_MODE,
	output logic [3:0] O_CURRENT_LIMIT_NINTHS,
	output logic [NUM_STRINGS-1:0] O_SINK_EN,
	output logic O_LEVEL_PICK,
	output logic O_SLEEP,
	output logic O_LATCHED_SHUTDOWN,
	output bssfs_pkg::bssfs_status_s [NUM_STRINGS-1:0] O_STATUS
);
	// ------------------------------------------------------------
	// local reset and shutdown
	// ------------------------------------------------------------
	// lockout and enable low act as a full reset of all digital state
	logic active;
	assign active = I_ENABLE & ~I_INPUT_UNDERVOLTAGE_LOCKOUT;

	function automatic logic [2:0] count_down(input bssfs_pkg::bssfs_status_s [NUM_STRINGS-1:0] st);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < NUM_STRINGS; i++)
			n = n + {2'h0, st[i].faulted};
		return n;
	endfunction : count_down

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	bssfs_pkg::bssfs_state_e state;
	bssfs_pkg::bssfs_state_e next_state;
	logic [3:0] limit;
	logic [3:0] next_limit;
	logic conducted;
	logic next_conducted;
	logic kill_all;
	logic next_kill_all;
	logic level;
	logic next_level;
	logic any_on;
	logic step_done;
	logic sleep_done;
	logic start_pulse;
	logic [NUM_STRINGS-1:0] fault_now;
	bssfs_pkg::bssfs_status_s [NUM_STRINGS-1:0] status;

	assign any_on = |(I_LED_STRING_ON & O_SINK_EN);
	assign start_pulse = (state == bssfs_pkg::BSSFS_OFF) && active;

	// ------------------------------------------------------------
	// timers
	// ------------------------------------------------------------
	bssfs_timer #(
		.COUNT(STEP_CYCLES)
	) u_step (
		.i_clk(I_MCLK),
		.i_rst_n(I_RESETN),
		.i_clear(next_state != bssfs_pkg::BSSFS_SOFT),
		.i_run(1'b1),
		.o_done(step_done)
	);

	bssfs_timer #(
		.COUNT(SLEEP_CYCLES)
	) u_sleep (
		.i_clk(I_MCLK),
		.i_rst_n(I_RESETN),
		.i_clear(any_on || !(state == bssfs_pkg::BSSFS_SOFT || state == bssfs_pkg::BSSFS_RUN)),
		.i_run(1'b1),
		.o_done(sleep_done)
	);

	// ------------------------------------------------------------
	// strings
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_STRINGS; g++)
		begin : g_str
			bssfs_string u_str (
				.i_clk(I_MCLK),
				.i_rst_n(I_RESETN),
				.i_active(active && state != bssfs_pkg::BSSFS_LATCH),
				.i_start(start_pulse),
				.i_stable(I_STABLE),
				.i_pwm_start(I_PWM_CYCLE_START),
				.i_overvoltage(I_OUTPUT_OVERVOLTAGE_LIMIT),
				.i_kill_all(kill_all),
				.i_sense(I_SENSE[g]),
				.o_status(status[g]),
				.o_fault_now(fault_now[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_limit = limit;
		next_conducted = conducted | any_on;
		next_kill_all = kill_all;
		next_level = level;
		// direct mode follows at once, others wait for cycle start
		if (I_DIRECT_PWM_MODE || I_PWM_CYCLE_START)
			next_level = I_LEVEL_PICK_INPUT;
		// a fault beyond three already down takes every string out
		if ((|fault_now) && count_down(status) > bssfs_pkg::MAX_DOWN_L)
			next_kill_all = 1'b1;
		if (!active)
		begin
			next_state = bssfs_pkg::BSSFS_OFF;
			next_limit = bssfs_pkg::LIMIT_OFF_L;
			next_conducted = 1'b0;
			next_kill_all = 1'b0;
			next_level = 1'b0;
		end
		else
		begin
			case (state)
				bssfs_pkg::BSSFS_OFF:
				begin
					next_state = bssfs_pkg::BSSFS_SOFT;
					next_limit = bssfs_pkg::LIMIT_FIRST_L;
					next_conducted = 1'b0;
				end
				bssfs_pkg::BSSFS_SOFT:
				begin
					if (step_done && conducted)
					begin
						next_limit = limit + 4'h1;
						next_conducted = any_on;
						if (limit + 4'h1 == bssfs_pkg::LIMIT_FULL_L)
							next_state = bssfs_pkg::BSSFS_RUN;
					end
					if (sleep_done)
						next_state = bssfs_pkg::BSSFS_SLEEP;
				end
				bssfs_pkg::BSSFS_RUN:
				begin
					if (sleep_done)
						next_state = bssfs_pkg::BSSFS_SLEEP;
				end
				bssfs_pkg::BSSFS_SLEEP:
				begin
					if (|I_LED_STRING_ON)
					begin
						next_state = bssfs_pkg::BSSFS_SOFT;
						next_limit = bssfs_pkg::LIMIT_FIRST_L;
						next_conducted = 1'b0;
					end
				end
				bssfs_pkg::BSSFS_LATCH:
				begin
					next_limit = bssfs_pkg::LIMIT_OFF_L;
				end
				default:
				begin
					next_state = bssfs_pkg::BSSFS_OFF;
				end
			endcase
			// latched until enable or power cycles
			if (I_OVER_TEMPERATURE || I_INPUT_SUPPLY_OVERVOLTAGE)
			begin
				next_state = bssfs_pkg::BSSFS_LATCH;
				next_limit = bssfs_pkg::LIMIT_OFF_L;
			end
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			state <= bssfs_pkg::BSSFS_OFF;
			limit <= bssfs_pkg::LIMIT_OFF_L;
			conducted <= 1'b0;
			kill_all <= 1'b0;
			level <= 1'b0;
		end
		else
		begin
			state <= next_state;
			limit <= next_limit;
			conducted <= next_conducted;
			kill_all <= next_kill_all;
			level <= next_level;
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	logic running;
	assign running = (state == bssfs_pkg::BSSFS_SOFT) || (state == bssfs_pkg::BSSFS_RUN);

	always_ff @(posedge I_MCLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			O_BOOST_SWITCH_EN <= 1'b0;
			O_LIGHT_LOAD_PULSE_MODE <= 1'b0;
			O_CURRENT_LIMIT_NINTHS <= bssfs_pkg::LIMIT_OFF_L;
			O_SINK_EN <= '0;
			O_LEVEL_PICK <= 1'b0;
			O_SLEEP <= 1'b0;
			O_LATCHED_SHUTDOWN <= 1'b0;
			O_STATUS <= '0;
		end
		else
		begin
			O_BOOST_SWITCH_EN <= running && active;
			O_LIGHT_LOAD_PULSE_MODE <= running && active && !(|I_LED_STRING_ON);
			O_CURRENT_LIMIT_NINTHS <= next_limit;
			for (int i = 0; i < NUM_STRINGS; i++)
				O_SINK_EN[i] <= status[i].enabled && state != bssfs_pkg::BSSFS_LATCH;
			O_LEVEL_PICK <= level;
			O_SLEEP <= state == bssfs_pkg::BSSFS_SLEEP;
			O_LATCHED_SHUTDOWN <= state == bssfs_pkg::BSSFS_LATCH;
			O_STATUS <= status;
		end
	end
endmodule : bssfs_top
`default_nettype wire

// >>> verification/bssfs_props.sv
// checker: timing relations at the sequencer top ports
`timescale 1ns/100ps
`default_nettype none
module bssfs_props #(
	parameter int unsigned NUM_STRINGS = 4
) (
	input wire logic I_MCLK,
	input wire logic I_RESETN,
	input wire logic I_ENABLE,
	input wire logic I_INPUT_UNDERVOLTAGE_LOCKOUT,
	input wire logic I_OVER_TEMPERATURE,
	input wire logic I_DIRECT_PWM_MODE,
	input wire logic I_LEVEL_PICK_INPUT,
	input wire logic O_BOOST_SWITCH_EN,
	input wire logic O_LIGHT_LOAD_PULSE_MODE,
	input wire logic [3:0] O_CURRENT_LIMIT_NINTHS,
	input wire logic [NUM_STRINGS-1:0] O_SINK_EN,
	input wire logic O_LEVEL_PICK,
	input wire logic O_SLEEP,
	input wire logic O_LATCHED_SHUTDOWN
);
	// ----
	// properties
	// ----
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RESETN);
	wire logic go = I_ENABLE & !I_INPUT_UNDERVOLTAGE_LOCKOUT;
	wire logic [3:0] lim = O_CURRENT_LIMIT_NINTHS;
	// three cycles of margin: status lags its cause by two
	sequence s_en_low; !I_ENABLE [*3]; endsequence
	sequence s_lock; I_INPUT_UNDERVOLTAGE_LOCKOUT [*3]; endsequence
	property p_en_off; s_en_low |-> !O_BOOST_SWITCH_EN && O_SINK_EN == '0 && !O_LATCHED_SHUTDOWN; endproperty
	a_en_off: assert property (p_en_off) else $error("enable low left outputs on");
	property p_lock; s_lock |-> !O_BOOST_SWITCH_EN && lim == 4'h0; endproperty
	a_lock: assert property (p_lock) else $error("lockout left boost on");
	property p_temp; I_OVER_TEMPERATURE && go |-> ##[1:2] O_LATCHED_SHUTDOWN; endproperty
	a_temp: assert property (p_temp) else $error("no latch on heat");
	property p_latch; O_LATCHED_SHUTDOWN && go |=> O_LATCHED_SHUTDOWN; endproperty
	a_latch: assert property (p_latch) else $error("latch dropped");
	property p_dark; O_LATCHED_SHUTDOWN [*3] |-> !O_BOOST_SWITCH_EN && O_SINK_EN == '0; endproperty
	a_dark: assert property (p_dark) else $error("latched yet driving");
	property p_first; $rose(O_BOOST_SWITCH_EN) |-> ##[0:1] lim == 4'h1; endproperty
	a_first: assert property (p_first) else $error("start limit wrong");
	property p_step;
		lim > $past(lim) && $past(lim) != 4'h0 |-> lim == $past(lim) + 4'h1 && lim <= 4'h9;
	endproperty
	a_step: assert property (p_step) else $error("limit jump");
	property p_pulse; O_LIGHT_LOAD_PULSE_MODE |-> O_BOOST_SWITCH_EN && !O_SLEEP; endproperty
	a_pulse: assert property (p_pulse) else $error("pulse mode off switching");
	property p_sleep; O_SLEEP |-> !O_BOOST_SWITCH_EN && !O_LATCHED_SHUTDOWN; endproperty
	a_sleep: assert property (p_sleep) else $error("switching asleep");
	// level register, then output flop: the pick shows two edges later
	property p_direct; go && I_DIRECT_PWM_MODE |=> ##1 O_LEVEL_PICK == $past(I_LEVEL_PICK_INPUT, 2); endproperty
	a_direct: assert property (p_direct) else $error("level pick late");
endmodule : bssfs_props
bind bssfs_top bssfs_props #(.NUM_STRINGS(NUM_STRINGS)) props (.*);
`default_nettype wire

// >>> verification/bssfs_far_side.sv
// model: led string sinks seen through the sense comparators
`timescale 1ns/100ps
`default_nettype none
module bssfs_far_side #(
	parameter logic [3:0] GND_MASK = 4'h8
) (
	input wire logic [3:0] i_sink_en,
	input wire logic [3:0] i_short,
	input wire logic [3:0] i_open,
	output bssfs_pkg::bssfs_sense_s [3:0] o_sense
);
	// ----
	// comparators
	// ----
	// no lag modelled: quicker than silicon
	always_comb
	begin
		for (int n = 0; n < 4; n++)
		begin
			o_sense[n].grounded = GND_MASK[n];
			o_sense[n].short_check = i_short[n] & ~GND_MASK[n];
			o_sense[n].at_target = i_sink_en[n] & ~i_open[n];
		end
	end
endmodule : bssfs_far_side
`default_nettype wire

// >>> verification/bssfs_top_test.sv
// testbench: self-checking run of the sequencer with its string model
`timescale 1ns/100ps
`default_nettype none
module bssfs_top_test;
	localparam int SC = 200;
	localparam int TC = 20;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic en = 1'b0, uv = 1'b0, iov = 1'b0, ot = 1'b0, ovl = 1'b0;
	logic st = 1'b1, pwm = 1'b0, dm = 1'b0, lp = 1'b0, lvl, boost, pmode, slp, lat;
	logic [3:0] on = 4'h0, sh = 4'h0, op = 4'h0, sink, lim, v;
	bssfs_pkg::bssfs_sense_s [3:0] sense;
	bssfs_pkg::bssfs_status_s [3:0] stat;
	int num_errors = 0;
	int samples_checked = 0;
	int i, k, t;
	always #2.5 clk = ~clk;
	bssfs_top #(.SLEEP_CYCLES(SC), .STEP_CYCLES(TC)) uut (.I_MCLK(clk), .I_RESETN(rst_n), .I_ENABLE(en),
		.I_INPUT_UNDERVOLTAGE_LOCKOUT(uv), .I_INPUT_SUPPLY_OVERVOLTAGE(iov), .I_OVER_TEMPERATURE(ot),
		.I_OUTPUT_OVERVOLTAGE_LIMIT(ovl), .I_STABLE(st), .I_PWM_CYCLE_START(pwm), .I_DIRECT_PWM_MODE(dm),
		.I_LEVEL_PICK_INPUT(lp), .I_LED_STRING_ON(on), .I_SENSE(sense), .O_BOOST_SWITCH_EN(boost),
		.O_LIGHT_LOAD_PULSE_MODE(pmode), .O_CURRENT_LIMIT_NINTHS(lim), .O_SINK_EN(sink),
		.O_LEVEL_PICK(lvl), .O_SLEEP(slp), .O_LATCHED_SHUTDOWN(lat), .O_STATUS(stat));
	bssfs_far_side far (.i_sink_en(sink), .i_short(sh), .i_open(op), .o_sense(sense));
	// ----
	// helpers
	// ----
	// reads right after an edge see the previous edge's outputs
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic chk(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1)
		begin
			num_errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic pulse(input int n);
		repeat (n)
		begin
			pwm <= 1'b1;
			tick(1);
			pwm <= 1'b0;
			tick(3);
		end
	endtask : pulse
	function automatic logic nxt_lvl(input logic o, input logic d, input logic p, input logic l);
		return (d | p) ? l : o;
	endfunction : nxt_lvl
	task automatic close_out;
		if (num_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	// ----
	// sequence
	// ----
	initial
	begin
		tick(20000);
		chk(1'b0, "timeout");
		close_out();
	end
	initial
	begin
		void'($urandom(32'h935a));
		tick(5);
		rst_n <= 1'b1;
		en <= 1'b1;
		on <= 4'hf;
		v = 4'h0;
		t = 0;
		for (i = 0; i < 12 * TC && v != 4'h9; i++)
		begin
			tick(1);
			t++;
			if (lim !== v)
			begin
				chk(lim === v + 4'h1 && (v == 4'h0 || t == TC), "ramp");
				v = lim;
				t = 0;
			end
		end
		chk(v === 4'h9 && sink === 4'h7, "ramp end");
		on <= 4'h0;
		tick(4);
		chk(pmode === 1'b1 && boost === 1'b1, "pulse mode");
		tick(SC - 14);
		chk(slp === 1'b0, "early sleep");
		tick(20);
		chk(slp === 1'b1 && boost === 1'b0, "no sleep");
		on <= 4'hf;
		tick(4);
		chk(slp === 1'b0 && lim === 4'h1, "wake");
		on <= 4'h0;
		tick(TC + 4);
		v = lim;
		tick(3 * TC);
		chk(lim === v, "dark step");
		on <= 4'hf;
		for (i = 0; i < TC + 4 && lim === v; i++)
			tick(1);
		chk(lim === v + 4'h1, "resume");
		for (k = 0; k < 2; k++)
		begin
			st <= 1'b0;
			sh[0] <= (k == 0);
			op[1] <= (k == 1);
			pulse(8);
			chk(stat[k].faulted === 1'b0, "unstable fault");
			st <= 1'b1;
			pulse(5);
			chk(stat[k].faulted === 1'b0, "early fault");
			pulse(1);
			tick(2);
			chk(stat[k].faulted === 1'b1 && sink[k] === 1'b0 && sink[2] === 1'b1, "fault");
		end
		for (k = 0; k < 3; k++)
		begin
			ot <= (k == 0);
			iov <= (k == 1);
			uv <= (k == 2);
			tick(5);
			chk(boost === 1'b0 && sink === 4'h0 && lat === (k < 2), "shutdown");
			ot <= 1'b0;
			iov <= 1'b0;
			uv <= 1'b0;
			tick(10);
			chk(boost === (k == 2) && lat === (k < 2), "release");
			en <= 1'b0;
			tick(5);
			chk(boost === 1'b0 && lat === 1'b0 && sink === 4'h0, "enable low");
			en <= 1'b1;
			tick(4);
			chk(lim === 4'h1 && sink === 4'h7, "restart");
		end
		// string 1 still open and never good: overvoltage must time out it alone
		ovl <= 1'b1;
		pulse(6);
		tick(2);
		chk(stat[1].faulted === 1'b1 && stat[0].faulted === 1'b0 && sink === 4'h5, "overvoltage");
		ovl <= 1'b0;
		op <= 4'h0;
		dm <= 1'b1;
		tick(1);
		for (i = 0; i < 400; i++)
		begin
			// level register then output flop: compare against two cycles back
			if (i > 1)
				chk(lvl === v[1], "level pick");
			v[1] = v[0];
			v[0] = nxt_lvl(v[0], dm, pwm, lp);
			dm <= 1'($urandom);
			lp <= 1'($urandom);
			pwm <= ($urandom % 4 == 0);
			ovl <= ($urandom % 16 == 0);
			on <= 4'($urandom);
			tick(1);
		end
		close_out();
	end
endmodule : bssfs_top_test
`default_nettype wire
